// ### tspm_pkg.sv
// Constants, types and state codes for the serially loaded tiny core.
// Assumes one clock domain and a host that shifts program frames serially.
// Contract
// - The core runs only a subset of the mid-range set: no special registers, no carry, no call stack.
// - The core has six working registers and a sixteen-word program store.
// - After a full frame the host asserts the strobe and the core stores the data at the address.
// - When loading is done the host raises the strobe and releases reset, and the program then runs.
// - Register 6 reads the four input pins and register 7 drives the eight output pins.
// - After programming and reset the core runs with no further help from the host.
package tspm_pkg;
    localparam int FRAME_W = 28;
    localparam int INSN_W = 14;
    localparam int PROG_DEPTH = 16;
    localparam int PC_W = 4;
    localparam int NUM_WREG = 6;
    localparam int DATA_W = 8;
    localparam int GPI_W = 4;
    localparam int GPO_W = 8;
    localparam logic [2:0] REG_IN = 3'h6;
    localparam logic [2:0] REG_OUT = 3'h7;
    localparam logic [GPO_W-1:0] GPO_RESET = 8'h00;
    localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 4'h0;
    // Instruction classes, bits 13:12
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;
    // Byte-oriented opcodes, bits 11:8
    localparam logic [3:0] OP_MOVWF = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUBWF = 4'h2;
    localparam logic [3:0] OP_DECF = 4'h3;
    localparam logic [3:0] OP_IORWF = 4'h4;
    localparam logic [3:0] OP_ANDWF = 4'h5;
    localparam logic [3:0] OP_XORWF = 4'h6;
    localparam logic [3:0] OP_ADDWF = 4'h7;
    localparam logic [3:0] OP_MOVF = 4'h8;
    localparam logic [3:0] OP_COMF = 4'h9;
    localparam logic [3:0] OP_INCF = 4'hA;
    localparam logic [3:0] OP_DECFSZ = 4'hB;
    localparam logic [3:0] OP_RRF = 4'hC;
    localparam logic [3:0] OP_RLF = 4'hD;
    localparam logic [3:0] OP_SWAPF = 4'hE;
    localparam logic [3:0] OP_INCFSZ = 4'hF;
    // Bit-oriented opcodes, bits 11:10
    localparam logic [1:0] BOP_CLR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_SKIPCLR = 2'h2;
    localparam logic [1:0] BOP_SKIPSET = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC = 2'b11
    } tspm_state_t;

    typedef struct packed {
        logic [INSN_W-1:0] addr;
        logic [INSN_W-1:0] data;
    } tspm_frame_t;
endpackage : tspm_pkg

// ### tspm_core.sv
// Serially loaded tiny core: program loader, two-phase fetch/execute, pin registers.
// Assumes inputs are synchronous to clk_sys and the host holds reset while loading.
`timescale 1ns/1ps
module tspm_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Programming port
    input wire logic prog_strobe_n,
    input wire logic prog_data,
    // Pins
    input wire logic [tspm_pkg::GPI_W-1:0] input_pin_bit,
    output logic [tspm_pkg::GPO_W-1:0] output_pin_bit
);
    logic rst_meta_reg;
    logic rst_n_sync;
    tspm_pkg::tspm_frame_t shift_reg;
    logic strobe_n_prev_reg;
    logic prog_we;
    logic [tspm_pkg::INSN_W-1:0] prog_mem [tspm_pkg::PROG_DEPTH];
    tspm_pkg::tspm_state_t state_reg;
    logic [tspm_pkg::PC_W-1:0] pc_reg;
    logic [tspm_pkg::PC_W-1:0] pc_next;
    logic [tspm_pkg::INSN_W-1:0] ir_reg;
    logic [tspm_pkg::DATA_W-1:0] w_reg;
    logic [tspm_pkg::DATA_W-1:0] wreg_file [tspm_pkg::NUM_WREG];
    logic [tspm_pkg::GPO_W-1:0] gpo_reg;
    logic [2:0] fsel;
    logic [tspm_pkg::DATA_W-1:0] fval;
    logic [tspm_pkg::DATA_W-1:0] kval;
    logic [tspm_pkg::DATA_W-1:0] result;
    logic w_we;
    logic f_we;
    logic skip;
    logic jump;
    logic exec;

    // Byte ALU shared by file and literal forms
    function automatic logic [tspm_pkg::DATA_W-1:0] alu(input logic [3:0] op,
            input logic [tspm_pkg::DATA_W-1:0] a, input logic [tspm_pkg::DATA_W-1:0] w);
        case (op)
            tspm_pkg::OP_SUBWF: alu = a - w;
            tspm_pkg::OP_IORWF: alu = a | w;
            tspm_pkg::OP_ANDWF: alu = a & w;
            tspm_pkg::OP_XORWF: alu = a ^ w;
            tspm_pkg::OP_ADDWF: alu = a + w;
            default: alu = a;
        endcase
    endfunction : alu

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // Loader runs through reset so the host can load while the core is held
    always_ff @(posedge clk_sys) begin
        shift_reg <= {shift_reg[tspm_pkg::FRAME_W-2:0], prog_data};
        strobe_n_prev_reg <= prog_strobe_n;
    end

    assign prog_we = strobe_n_prev_reg && !prog_strobe_n;

    // Store survives reset; only the low address bits select a word
    always_ff @(posedge clk_sys) begin
        if (prog_we) begin
            prog_mem[shift_reg.addr[tspm_pkg::PC_W-1:0]] <= shift_reg.data;
        end
    end

    assign exec = (state_reg == tspm_pkg::ST_EXEC);

    // Sequencer: fetch then execute, forever after reset release
    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state_reg <= tspm_pkg::ST_IDLE;
            pc_reg <= tspm_pkg::PC_RESET;
            ir_reg <= '0;
        end else begin
            case (state_reg)
                tspm_pkg::ST_IDLE: state_reg <= tspm_pkg::ST_FETCH;
                tspm_pkg::ST_FETCH: begin
                    ir_reg <= prog_mem[pc_reg];
                    state_reg <= tspm_pkg::ST_EXEC;
                end
                tspm_pkg::ST_EXEC: begin
                    pc_reg <= pc_next;
                    state_reg <= tspm_pkg::ST_FETCH;
                end
                default: state_reg <= tspm_pkg::ST_IDLE;
            endcase
        end
    end

    assign fsel = ir_reg[2:0];
    assign kval = ir_reg[7:0];

    // Register 6 is the input pins, 7 the output latch
    always_comb begin
        if (fsel == tspm_pkg::REG_IN) begin
            fval = {{(tspm_pkg::DATA_W-tspm_pkg::GPI_W){1'b0}}, input_pin_bit};
        end else if (fsel == tspm_pkg::REG_OUT) begin
            fval = gpo_reg;
        end else begin
            fval = wreg_file[fsel];
        end
    end

    // Decode; no carry or status, so rotates wrap and call/return act as no-ops
    always_comb begin
        result = '0;
        w_we = 1'b0;
        f_we = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        case (ir_reg[13:12])
            tspm_pkg::CLS_BYTE: begin
                case (ir_reg[11:8])
                    tspm_pkg::OP_MOVWF: result = w_reg;
                    tspm_pkg::OP_CLR: result = '0;
                    tspm_pkg::OP_DECF, tspm_pkg::OP_DECFSZ: result = fval - 8'h01;
                    tspm_pkg::OP_INCF, tspm_pkg::OP_INCFSZ: result = fval + 8'h01;
                    tspm_pkg::OP_COMF: result = ~fval;
                    tspm_pkg::OP_RRF: result = {fval[0], fval[7:1]};
                    tspm_pkg::OP_RLF: result = {fval[6:0], fval[7]};
                    tspm_pkg::OP_SWAPF: result = {fval[3:0], fval[7:4]};
                    default: result = alu(ir_reg[11:8], fval, w_reg);
                endcase
                if (ir_reg[11:8] == tspm_pkg::OP_MOVWF) begin
                    f_we = ir_reg[7];
                end else begin
                    f_we = ir_reg[7];
                    w_we = !ir_reg[7];
                end
                if (ir_reg[11:8] == tspm_pkg::OP_DECFSZ || ir_reg[11:8] == tspm_pkg::OP_INCFSZ) begin
                    skip = (result == 8'h00);
                end
            end
            tspm_pkg::CLS_BIT: begin
                result = fval;
                case (ir_reg[11:10])
                    tspm_pkg::BOP_CLR: begin
                        result[ir_reg[9:7]] = 1'b0;
                        f_we = 1'b1;
                    end
                    tspm_pkg::BOP_SET: begin
                        result[ir_reg[9:7]] = 1'b1;
                        f_we = 1'b1;
                    end
                    tspm_pkg::BOP_SKIPCLR: skip = !fval[ir_reg[9:7]];
                    default: skip = fval[ir_reg[9:7]];
                endcase
            end
            tspm_pkg::CLS_JUMP: jump = ir_reg[11];
            default: begin
                if (ir_reg[11:10] == 2'h0) begin
                    result = kval;
                    w_we = 1'b1;
                end else if (ir_reg[11:10] == 2'h2) begin
                    result = alu({2'h1, ir_reg[9:8]}, kval, w_reg);
                    w_we = (ir_reg[9:8] != 2'h3);
                end else if (ir_reg[11:10] == 2'h3) begin
                    result = alu(ir_reg[9] ? tspm_pkg::OP_ADDWF : tspm_pkg::OP_SUBWF, kval, w_reg);
                    w_we = 1'b1;
                end
            end
        endcase
    end

    always_comb begin
        if (jump) begin
            pc_next = ir_reg[tspm_pkg::PC_W-1:0];
        end else if (skip) begin
            pc_next = pc_reg + 4'h2;
        end else begin
            pc_next = pc_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            w_reg <= tspm_pkg::WREG_RESET;
        end else if (exec && w_we) begin
            w_reg <= result;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < tspm_pkg::NUM_WREG; gi++) begin : g_wreg
            always_ff @(posedge clk_sys or negedge rst_n_sync) begin
                if (!rst_n_sync) begin
                    wreg_file[gi] <= tspm_pkg::WREG_RESET;
                end else if (exec && f_we && fsel == 3'(gi)) begin
                    wreg_file[gi] <= result;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            gpo_reg <= tspm_pkg::GPO_RESET;
        end else if (exec && f_we && fsel == tspm_pkg::REG_OUT) begin
            gpo_reg <= result;
        end
    end

    assign output_pin_bit = gpo_reg;

    sequence s_fetch_exec;
        state_reg == tspm_pkg::ST_FETCH ##1 state_reg == tspm_pkg::ST_EXEC;
    endsequence

    property p_shift;
        @(posedge clk_sys) disable iff (!rst_n_sync)
        1'b1 |=> shift_reg == {$past(shift_reg[tspm_pkg::FRAME_W-2:0]), $past(prog_data)};
    endproperty
    a_shift: assert property (p_shift) else $error("shifter lost a bit");

    property p_store;
        @(posedge clk_sys)
        prog_we |=> prog_mem[$past(shift_reg.addr[3:0])] == $past(shift_reg.data);
    endproperty
    a_store: assert property (p_store) else $error("program word not stored");

    property p_boot;
        @(posedge clk_sys) disable iff (!rst_n_sync)
        $rose(rst_n_sync) |-> pc_reg == 4'h0 ##1 s_fetch_exec;
    endproperty
    a_boot: assert property (p_boot) else $error("core did not start at word 0");

    property p_run;
        @(posedge clk_sys) disable iff (!rst_n_sync)
        state_reg == tspm_pkg::ST_EXEC |=> s_fetch_exec;
    endproperty
    a_run: assert property (p_run) else $error("core stopped sequencing");

    property p_gpo;
        @(posedge clk_sys) disable iff (!rst_n_sync)
        exec && f_we && fsel == tspm_pkg::REG_OUT |=> output_pin_bit == $past(result);
    endproperty
    a_gpo: assert property (p_gpo) else $error("output pins not updated");

    property p_gpi;
        @(posedge clk_sys) disable iff (!rst_n_sync)
        exec && ir_reg[13:7] == 7'h10 && fsel == tspm_pkg::REG_IN
            |=> w_reg == {4'h0, $past(input_pin_bit)};
    endproperty
    a_gpi: assert property (p_gpi) else $error("input pins not read");

    property p_call;
        @(posedge clk_sys) disable iff (!rst_n_sync)
        exec && ir_reg[13:11] == 3'h4 |=> pc_reg == $past(pc_reg) + 4'h1 && w_reg == $past(w_reg);
    endproperty
    a_call: assert property (p_call) else $error("call changed state");

    property p_goto;
        @(posedge clk_sys) disable iff (!rst_n_sync)
        exec && ir_reg[13:11] == 3'h5 |=> pc_reg == $past(ir_reg[3:0]);
    endproperty
    a_goto: assert property (p_goto) else $error("jump target wrong");
endmodule : tspm_core

// ### tspm_host.sv
// Programming host model: shifts 28-bit frames serially and strobes each one.
// Assumes the core samples prog_data on every rising edge of clk_sys.
`timescale 1ns/1ps
module tspm_host (
    // Clock
    input wire logic clk_sys,
    // Programming port
    output logic prog_strobe_n,
    output logic prog_data
);
    // Set to stretch the idle gap between frames
    logic slow;

    initial begin
        prog_strobe_n = 1'b1;
        prog_data = 1'b0;
        slow = 1'b0;
    end

    task automatic send_word(input logic [tspm_pkg::INSN_W-1:0] addr,
                             input logic [tspm_pkg::INSN_W-1:0] word);
        tspm_pkg::tspm_frame_t frame;
        int gap;
        frame.addr = addr;
        frame.data = word;
        for (int i = tspm_pkg::FRAME_W - 1; i >= 0; i--) begin
            @(posedge clk_sys);
            #1 prog_data = frame[i];
        end
        @(posedge clk_sys);
        #1 prog_strobe_n = 1'b0;
        prog_data = ~prog_data;
        @(posedge clk_sys);
        #1 prog_strobe_n = 1'b1;
        // Idle data keeps toggling so a late sample never looks valid
        gap = slow ? 7 : 1;
        repeat (gap) begin
            @(posedge clk_sys);
            #1 prog_data = ~prog_data;
        end
    endtask : send_word
endmodule : tspm_host

// ### tb_tiny_serial_programmed_mcu.sv
// Self-checking bench for the serially loaded core with a host model.
// Assumes the core writes register 7 to the pins and reads pins as register 6.
`timescale 1ns/1ps
module tb_tiny_serial_programmed_mcu;
    logic clk_sys;
    logic resetn;
    logic prog_strobe_n;
    logic prog_data;
    logic [tspm_pkg::GPI_W-1:0] input_pin_bit;
    logic [tspm_pkg::GPO_W-1:0] output_pin_bit;
    int err_total;
    int checks_done;

    tspm_core dut (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .prog_strobe_n(prog_strobe_n),
        .prog_data(prog_data),
        .input_pin_bit(input_pin_bit),
        .output_pin_bit(output_pin_bit)
    );

    tspm_host host (
        .clk_sys(clk_sys),
        .prog_strobe_n(prog_strobe_n),
        .prog_data(prog_data)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cycles

    task automatic check_pins(input logic [tspm_pkg::GPO_W-1:0] exp);
        checks_done++;
        if (output_pin_bit !== exp) begin
            err_total++;
            $display("wrong value time %0t got 0x%h exp 0x%h", $time, output_pin_bit, exp);
        end
    endtask : check_pins

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic test_reset_pins;
        input_pin_bit = 4'hF;
        wait_cycles(2);
        check_pins(8'h00);
    endtask : test_reset_pins

    // Copy pins plus a literal; high address bits set to prove they are ignored
    task automatic test_io_loop;
        logic [3:0] vals [4];
        vals = '{4'h0, 4'h5, 4'hA, 4'hF};
        host.send_word(14'h1550, 14'h0806);
        host.send_word(14'h2AA1, 14'h3EF5);
        host.send_word(14'h3FF2, 14'h0087);
        host.send_word(14'h0003, 14'h2800);
        resetn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            input_pin_bit = vals[i];
            wait_cycles(30);
            check_pins(8'({4'h0, vals[i]} + 8'hF5));
        end
    endtask : test_io_loop

    // Rewrite one word from a slow host; the rest survives reset
    task automatic test_rewrite;
        resetn = 1'b0;
        #1;
        check_pins(8'h00);
        host.slow = 1'b1;
        host.send_word(14'h0001, 14'h3AFF);
        host.slow = 1'b0;
        input_pin_bit = 4'h6;
        wait_cycles(1);
        resetn = 1'b1;
        wait_cycles(30);
        check_pins(8'hF9);
    endtask : test_rewrite

    // Working register arithmetic, then a self loop that must hold the pins
    task automatic test_wregs;
        logic [13:0] prog [7];
        prog = '{14'h3005, 14'h0085, 14'h0A85, 14'h0A85, 14'h0805, 14'h0087, 14'h2806};
        resetn = 1'b0;
        for (int i = 0; i < 7; i++) begin
            host.send_word(14'(i), prog[i]);
        end
        resetn = 1'b1;
        wait_cycles(30);
        check_pins(8'h07);
        input_pin_bit = 4'h9;
        wait_cycles(60);
        check_pins(8'h07);
    endtask : test_wregs

    // Swap, xor, skip on zero, literal logic, rotates and subtract from literal
    task automatic test_byte_ops;
        logic [13:0] prog [16];
        prog = '{14'h303C, 14'h0080, 14'h0E00, 14'h0680, 14'h0F80, 14'h3011,
                 14'h390F, 14'h3850, 14'h0081, 14'h0C81, 14'h0D01, 14'h3C60,
                 14'h0981, 14'h0701, 14'h0087, 14'h280F};
        resetn = 1'b0;
        for (int i = 0; i < 16; i++) begin
            host.send_word(14'(i), prog[i]);
        end
        resetn = 1'b1;
        wait_cycles(50);
        check_pins(8'h63);
    endtask : test_byte_ops

    // Bit set, clear and tests; a real call would loop back and never reach the pins
    task automatic test_bit_ops;
        logic [13:0] prog [16];
        prog = '{14'h300A, 14'h0082, 14'h3003, 14'h0282, 14'h0B82, 14'h1782,
                 14'h1F82, 14'h0182, 14'h1802, 14'h0182, 14'h2000, 14'h3455,
                 14'h1082, 14'h0402, 14'h0087, 14'h280F};
        resetn = 1'b0;
        for (int i = 0; i < 16; i++) begin
            host.send_word(14'(i), prog[i]);
        end
        resetn = 1'b1;
        wait_cycles(50);
        check_pins(8'h87);
        wait_cycles(30);
        check_pins(8'h87);
    endtask : test_bit_ops

    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        $display("watchdog expired at %0t", $time);
        give_verdict();
    end

    initial begin
        resetn = 1'b0;
        input_pin_bit = 4'h0;
        err_total = 0;
        checks_done = 0;
        wait_cycles(10);
        test_reset_pins();
        test_io_loop();
        test_rewrite();
        test_wregs();
        test_byte_ops();
        test_bit_ops();
        give_verdict();
    end
endmodule : tb_tiny_serial_programmed_mcu
